// ---- rtl/dss_startup_seq.sv ----
// Start-up sequencer and 2B+D transparency control for a 2B1Q line end
`timescale 1ns/1ps
module dss_startup_seq (
  input  wire logic                           core_clk,
  input  wire logic                           rst,
  input  wire logic                           lt_mode,
  input  wire logic                           filter_reset_request,
  input  wire logic                           insertion_loss_test,
  input  wire logic                           tone_detect,
  input  wire logic                           startup_request,
  input  wire logic                           loopback_request,
  input  wire logic                           deactivate_request,
  input  wire logic                           transparency_block,
  input  wire logic                           frame_tick,
  input  wire logic                           sym_tick,
  input  wire logic                           line_signal_detect,
  input  wire logic                           train_done,
  input  wire logic                           sync_word_lock,
  input  wire logic                           zero_payload_detect,
  input  wire logic                           superframe_lock,
  input  wire logic [dss_pkg::PAYLOAD_W-1:0]  sys_tx_data,
  input  wire logic                           sys_tx_valid,
  output logic                                sys_tx_ready,
  input  wire logic                           line_tx_ready,
  output logic [dss_pkg::PAYLOAD_W-1:0]       line_tx_data,
  output logic                                line_tx_valid,
  input  wire logic [dss_pkg::PAYLOAD_W-1:0]  line_rx_data,
  input  wire logic                           line_rx_valid,
  output logic [dss_pkg::PAYLOAD_W-1:0]       sys_rx_data,
  output logic                                sys_rx_valid,
  output dss_pkg::dss_tx_ctrl_s               tx_ctrl,
  output dss_pkg::dss_state_e                 seq_state,
  output logic                                insertion_loss_test_active,
  output logic                                woke_by_tone,
  output logic                                loopback_active
);

  dss_pkg::dss_core_s st;
  dss_pkg::dss_core_s next_st;

  logic [dss_pkg::PAYLOAD_W-1:0] fifo_data;
  logic                          fifo_valid;
  logic [dss_pkg::FRAME_CNT_W-1:0] tone_limit;
  logic                          signal_fell;
  logic                          pass_payload;
  logic                          lt_zeros;
  logic [dss_pkg::PAYLOAD_W-1:0] forced_value;

  dss_fifo #(
    .WIDTH (dss_pkg::PAYLOAD_W),
    .DEPTH (dss_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_data   (sys_tx_data),
    .in_valid  (sys_tx_valid),
    .in_ready  (sys_tx_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (line_tx_ready)
  );

  assign tone_limit  = lt_mode ? dss_pkg::LT_TONE_FRAMES
                               : dss_pkg::NT_TONE_FRAMES;
  assign signal_fell = st.prev_signal && !line_signal_detect;

  // Payload forcing: loopback overrides the block, as the far end needs it
  assign pass_payload = (st.state == dss_pkg::ST_NORMAL) &&
                        !transparency_block;
  assign lt_zeros     = lt_mode && ((st.state == dss_pkg::ST_READY) ||
                                    (st.state == dss_pkg::ST_NORMAL));
  assign forced_value = lt_zeros ? dss_pkg::PAYLOAD_ZEROS
                                 : dss_pkg::PAYLOAD_ONES;

  always_comb
  begin
    next_st = st;
    next_st.prev_signal = line_signal_detect;
    next_st.line_valid  = 1'b0;
    next_st.rx_valid    = line_rx_valid;

    // Higher priority requests pre-empt the start-up sequence
    if (filter_reset_request)
    begin
      next_st.state           = dss_pkg::ST_RESET;
      next_st.frame_cnt       = dss_pkg::FRAME_CNT_RST;
      next_st.sym_cnt         = dss_pkg::SYM_CNT_RST;
      next_st.loopback_active = 1'b0;
    end
    else if (insertion_loss_test)
    begin
      next_st.state           = dss_pkg::ST_INSERTION_LOSS_TEST;
      next_st.loopback_active = 1'b0;
    end
    else
    begin
      case (st.state)
        dss_pkg::ST_RESET:
        begin
          next_st.frame_cnt = dss_pkg::FRAME_CNT_RST;
          next_st.sym_cnt   = dss_pkg::SYM_CNT_RST;
          if (tone_detect || startup_request)
          begin
            next_st.state        = dss_pkg::ST_TONE;
            next_st.woke_by_tone = tone_detect;
          end
        end
        dss_pkg::ST_TONE:
        begin
          if (sym_tick)
            next_st.sym_cnt = dss_pkg::SYM_CNT_W'(st.sym_cnt + 1'b1);
          if (frame_tick)
          begin
            if (st.frame_cnt == tone_limit - 1'b1)
            begin
              next_st.frame_cnt = dss_pkg::FRAME_CNT_RST;
              next_st.state = lt_mode ? dss_pkg::ST_QUIET
                                      : dss_pkg::ST_SYNC_ONLY;
            end
            else
              next_st.frame_cnt = dss_pkg::FRAME_CNT_W'(st.frame_cnt + 1'b1);
          end
        end
        dss_pkg::ST_SYNC_ONLY:
          if (train_done)
            next_st.state = lt_mode ? dss_pkg::ST_READY
                                    : dss_pkg::ST_QUIET;
        dss_pkg::ST_QUIET:
          if (lt_mode && signal_fell)
            next_st.state = dss_pkg::ST_SYNC_ONLY;
          else if (!lt_mode && sync_word_lock && zero_payload_detect)
            next_st.state = dss_pkg::ST_READY;
        dss_pkg::ST_READY:
          if (superframe_lock)
            next_st.state = dss_pkg::ST_NORMAL;
        dss_pkg::ST_NORMAL:
        begin
          // Loopback ranks below every start-up cause
          next_st.loopback_active = loopback_request && !startup_request &&
                                    !tone_detect;
          if (deactivate_request)
          begin
            next_st.state           = dss_pkg::ST_RESET;
            next_st.loopback_active = 1'b0;
          end
        end
        dss_pkg::ST_INSERTION_LOSS_TEST: next_st.state = dss_pkg::ST_RESET;
        default:           next_st.state = dss_pkg::ST_RESET;
      endcase
    end

    // Forced data still drains the FIFO, so the system side stalls only when line_tx_ready stays low until the FIFO fills
    if (line_tx_ready)
    begin
      next_st.line_valid = 1'b1;
      if (st.loopback_active && st.state == dss_pkg::ST_NORMAL)
        next_st.line_data = st.loop_data;
      else if (pass_payload && fifo_valid)
        next_st.line_data = fifo_data;
      else
        next_st.line_data = forced_value;
    end

    if (line_rx_valid)
    begin
      next_st.loop_data = line_rx_data;
      next_st.rx_data   = superframe_lock ? line_rx_data
                                          : dss_pkg::PAYLOAD_ONES;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      st          <= '0;
      st.state    <= dss_pkg::ST_RESET;
      st.rx_data  <= dss_pkg::PAYLOAD_ONES;
    end
    else
      st <= next_st;
  end

  // Line transmitter control decoded from the state
  always_comb
  begin
    tx_ctrl = '0;
    case (st.state)
      dss_pkg::ST_TONE:
      begin
        tx_ctrl.enable = 1'b1;
        tx_ctrl.tone   = 1'b1;
        tx_ctrl.quat   = st.sym_cnt[2] ? dss_pkg::QUAT_NEG3
                                       : dss_pkg::QUAT_POS3;
      end
      dss_pkg::ST_SYNC_ONLY:
      begin
        tx_ctrl.enable        = 1'b1;
        tx_ctrl.sync_word     = 1'b1;
        tx_ctrl.overhead_ones = 1'b1;
      end
      dss_pkg::ST_READY:
      begin
        tx_ctrl.enable             = 1'b1;
        tx_ctrl.sync_word          = 1'b1;
        tx_ctrl.inverted_sync_word = lt_mode;
        tx_ctrl.overhead_ones      = !lt_mode;
      end
      dss_pkg::ST_NORMAL:
      begin
        tx_ctrl.enable             = 1'b1;
        tx_ctrl.sync_word          = 1'b1;
        tx_ctrl.inverted_sync_word = 1'b1;
      end
      default: tx_ctrl = '0;
    endcase
  end

  assign seq_state       = st.state;
  assign insertion_loss_test_active    = (st.state == dss_pkg::ST_INSERTION_LOSS_TEST);
  assign woke_by_tone    = st.woke_by_tone;
  assign loopback_active = st.loopback_active;
  assign line_tx_data    = st.line_data;
  assign line_tx_valid   = st.line_valid;
  assign sys_rx_data     = st.rx_data;
  assign sys_rx_valid    = st.rx_valid;

  property p_tone_pattern;
    @(posedge core_clk) disable iff (rst)
    tx_ctrl.tone |-> (tx_ctrl.quat == (st.sym_cnt[2] ? 2'h0 : 2'h2)) &&
                     !tx_ctrl.sync_word;
  endproperty
  a_tone_pattern: assert property (p_tone_pattern)
    else $error("tone symbol wrong or sync word present");

  property p_tone_len;
    @(posedge core_clk) disable iff (rst)
    (st.state == dss_pkg::ST_TONE && frame_tick && !filter_reset_request &&
     !insertion_loss_test && st.frame_cnt == (lt_mode ? 3'h1 : 3'h5))
    |=> st.state != dss_pkg::ST_TONE;
  endproperty
  a_tone_len: assert property (p_tone_len)
    else $error("tone did not end at its frame count");

  property p_sync_only;
    @(posedge core_clk) disable iff (rst)
    st.state == dss_pkg::ST_SYNC_ONLY |->
      tx_ctrl.sync_word && !tx_ctrl.inverted_sync_word &&
      tx_ctrl.overhead_ones;
  endproperty
  a_sync_only: assert property (p_sync_only)
    else $error("sync-only pattern malformed");

  property p_lt_zero;
    @(posedge core_clk) disable iff (rst)
    (lt_mode && st.state == dss_pkg::ST_READY && line_tx_ready)
    |=> line_tx_data == 18'h00000 && tx_ctrl.inverted_sync_word;
  endproperty
  a_lt_zero: assert property (p_lt_zero)
    else $error("zero-payload pattern not zero");

  property p_nt_block;
    @(posedge core_clk) disable iff (rst)
    (!lt_mode && transparency_block && !st.loopback_active && line_tx_ready)
    |=> line_tx_data == 18'h3ffff;
  endproperty
  a_nt_block: assert property (p_nt_block)
    else $error("upstream payload not forced to ones");

  property p_normal_hold;
    @(posedge core_clk) disable iff (rst)
    (st.state == dss_pkg::ST_NORMAL && !deactivate_request &&
     !filter_reset_request && !insertion_loss_test)
    |=> st.state == dss_pkg::ST_NORMAL;
  endproperty
  a_normal_hold: assert property (p_normal_hold)
    else $error("normal pattern left without deactivation");

  property p_reset_first;
    @(posedge core_clk) disable iff (rst)
    filter_reset_request |=> st.state == dss_pkg::ST_RESET;
  endproperty
  a_reset_first: assert property (p_reset_first)
    else $error("filter reset did not win");

  property p_nt_silent;
    @(posedge core_clk) disable iff (rst)
    (!lt_mode && st.state == dss_pkg::ST_QUIET) |-> !tx_ctrl.enable;
  endproperty
  a_nt_silent: assert property (p_nt_silent)
    else $error("user end transmits while silent");

  property p_lt_t3;
    @(posedge core_clk) disable iff (rst)
    (lt_mode && st.state == dss_pkg::ST_QUIET && $fell(line_signal_detect) &&
     !filter_reset_request && !insertion_loss_test)
    |=> st.state == dss_pkg::ST_SYNC_ONLY ##0 tx_ctrl.sync_word;
  endproperty
  a_lt_t3: assert property (p_lt_t3)
    else $error("network did not answer silence");

  property p_rx_pass;
    @(posedge core_clk) disable iff (rst)
    (line_rx_valid && superframe_lock) |=> sys_rx_data == $past(line_rx_data)
      && sys_rx_valid;
  endproperty
  a_rx_pass: assert property (p_rx_pass)
    else $error("received payload not passed after lock");

endmodule

// ---- rtl/dss_pkg.sv ----
// Shared constants and types for the line start-up sequencer
package dss_pkg;

  localparam int unsigned PAYLOAD_W      = 18;
  localparam int unsigned FIFO_DEPTH     = 16;
  localparam int unsigned FRAME_CNT_W    = 3;
  localparam int unsigned SYM_CNT_W      = 3;

  // Wake-tone lengths in frames for each line end
  localparam logic [FRAME_CNT_W-1:0] NT_TONE_FRAMES = 3'h6;
  localparam logic [FRAME_CNT_W-1:0] LT_TONE_FRAMES = 3'h2;

  // Quaternary symbol codes used while a tone is sent
  localparam logic [1:0] QUAT_POS3 = 2'h2;
  localparam logic [1:0] QUAT_NEG3 = 2'h0;

  // Forced 2B+D payload values
  localparam logic [PAYLOAD_W-1:0] PAYLOAD_ONES  = 18'h3ffff;
  localparam logic [PAYLOAD_W-1:0] PAYLOAD_ZEROS = 18'h00000;

  // Reset values
  localparam logic [FRAME_CNT_W-1:0] FRAME_CNT_RST = 3'h0;
  localparam logic [SYM_CNT_W-1:0]   SYM_CNT_RST   = 3'h0;

  // Gray coded along the user-end path
  typedef enum logic [2:0] {
    ST_RESET     = 3'h0,
    ST_TONE      = 3'h1,
    ST_SYNC_ONLY = 3'h3,
    ST_QUIET     = 3'h2,
    ST_READY     = 3'h6,
    ST_NORMAL    = 3'h7,
    ST_INSERTION_LOSS_TEST     = 3'h5
  } dss_state_e;

  typedef struct packed {
    logic                 sync_word;
    logic                 inverted_sync_word;
    logic                 overhead_ones;
    logic                 tone;
    logic                 enable;
    logic [1:0]           quat;
  } dss_tx_ctrl_s;

  typedef struct packed {
    dss_state_e             state;
    logic [FRAME_CNT_W-1:0] frame_cnt;
    logic [SYM_CNT_W-1:0]   sym_cnt;
    logic                   prev_signal;
    logic                   woke_by_tone;
    logic                   loopback_active;
    logic [PAYLOAD_W-1:0]   loop_data;
    logic [PAYLOAD_W-1:0]   line_data;
    logic                   line_valid;
    logic [PAYLOAD_W-1:0]   rx_data;
    logic                   rx_valid;
  } dss_core_s;

  typedef struct packed {
    logic [$clog2(FIFO_DEPTH):0]   count;
    logic [$clog2(FIFO_DEPTH)-1:0] wr_ptr;
    logic [$clog2(FIFO_DEPTH)-1:0] rd_ptr;
  } dss_fifo_s;

endpackage

// ---- rtl/dss_fifo.sv ----
// Upstream payload FIFO with valid/ready on both sides
`timescale 1ns/1ps
module dss_fifo #(
  parameter int unsigned WIDTH = dss_pkg::PAYLOAD_W,
  parameter int unsigned DEPTH = dss_pkg::FIFO_DEPTH
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  dss_pkg::dss_fifo_s st;
  dss_pkg::dss_fifo_s next_st;
  logic push;
  logic pop;

  assign in_ready  = (st.count != FULL_COUNT);
  assign out_valid = (st.count != '0);
  assign out_data  = mem[st.rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    next_st = st;
    if (push)
    begin
      next_st.wr_ptr = AW'(st.wr_ptr + 1'b1);
    end
    if (pop)
    begin
      next_st.rd_ptr = AW'(st.rd_ptr + 1'b1);
    end
    case ({push, pop})
      2'b10:   next_st.count = (AW+1)'(st.count + 1'b1);
      2'b01:   next_st.count = (AW+1)'(st.count - 1'b1);
      default: next_st.count = st.count;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Storage carries no reset; only the count defines what is valid
  always_ff @(posedge core_clk)
  begin
    if (push)
    begin
      mem[st.wr_ptr] <= in_data;
    end
  end

endmodule

// ---- sim/dss_ctrl_model.sv ----
// Far-end controller model that owns the payload block flag
`timescale 1ns/1ps
module dss_ctrl_model (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic sf_tick,
  input  wire logic link_up,
  input  wire logic loop_msg,
  output logic      transparency_block
);
  logic [1:0] run_cnt;
  // Count saturates at three so a long run of link-ups never wraps
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      run_cnt            <= 2'h0;
      transparency_block <= 1'b1;
    end
    else
    begin
      if (sf_tick && !link_up)
        run_cnt <= 2'h0;
      else if (sf_tick && run_cnt != 2'h3)
        run_cnt <= run_cnt + 2'h1;
      if (sf_tick && link_up && run_cnt == 2'h2)
        transparency_block <= 1'b0;
      if (loop_msg)
        transparency_block <= 1'b0;
    end
  end
endmodule

// ---- sim/dss_startup_seq_tb.sv ----
// Self-checking bench for the line start-up sequencer
`timescale 1ns/1ps
module dss_startup_seq_tb;
  logic                  core_clk = 1'b0;
  logic                  rst = 1'b1;
  logic                  lt_mode = 1'b0, filter_reset_request = 1'b0;
  logic                  insertion_loss_test = 1'b0, tone_detect = 1'b0;
  logic                  startup_request = 1'b0, loopback_request = 1'b0;
  logic                  deactivate_request = 1'b0, frame_tick = 1'b0;
  logic                  sym_tick = 1'b0, line_signal_detect = 1'b0;
  logic                  train_done = 1'b0, sync_word_lock = 1'b0;
  logic                  zero_payload_detect = 1'b0, superframe_lock = 1'b0;
  logic                  sys_tx_valid = 1'b0, line_tx_ready = 1'b0;
  logic                  line_rx_valid = 1'b0, sf_tick = 1'b0;
  logic                  link_up = 1'b0, loop_msg = 1'b0;
  logic [17:0]           sys_tx_data = 18'h0, line_rx_data = 18'h0;
  logic [17:0]           line_tx_data, sys_rx_data, d;
  logic                  transparency_block, sys_tx_ready, line_tx_valid;
  logic                  sys_rx_valid, insertion_loss_test_active, woke_by_tone;
  logic                  loopback_active;
  dss_pkg::dss_tx_ctrl_s tc;
  dss_pkg::dss_state_e   st;
  int                    n_mismatch = 0, comparisons = 0;

  always #10 core_clk = ~core_clk;

  dss_ctrl_model dss_ctrl_model_inst (.core_clk(core_clk), .rst(rst),
    .sf_tick(sf_tick), .link_up(link_up), .loop_msg(loop_msg),
    .transparency_block(transparency_block));

  dss_startup_seq dss_startup_seq_inst (.core_clk(core_clk), .rst(rst),
    .lt_mode(lt_mode), .filter_reset_request(filter_reset_request),
    .insertion_loss_test(insertion_loss_test), .tone_detect(tone_detect),
    .startup_request(startup_request), .loopback_request(loopback_request),
    .deactivate_request(deactivate_request),
    .transparency_block(transparency_block), .frame_tick(frame_tick),
    .sym_tick(sym_tick), .line_signal_detect(line_signal_detect),
    .train_done(train_done), .sync_word_lock(sync_word_lock),
    .zero_payload_detect(zero_payload_detect),
    .superframe_lock(superframe_lock), .sys_tx_data(sys_tx_data),
    .sys_tx_valid(sys_tx_valid), .sys_tx_ready(sys_tx_ready),
    .line_tx_ready(line_tx_ready), .line_tx_data(line_tx_data),
    .line_tx_valid(line_tx_valid), .line_rx_data(line_rx_data),
    .line_rx_valid(line_rx_valid), .sys_rx_data(sys_rx_data),
    .sys_rx_valid(sys_rx_valid), .tx_ctrl(tc), .seq_state(st),
    .insertion_loss_test_active(insertion_loss_test_active), .woke_by_tone(woke_by_tone),
    .loopback_active(loopback_active));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string what);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t %s", $time, what);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask

  task automatic frames(input int n);
    repeat (n)
    begin
      frame_tick = 1'b1;
      step(1);
      frame_tick = 1'b0;
      step(2);
    end
  endtask

  task automatic syms(input int n);
    repeat (n)
    begin
      sym_tick = 1'b1;
      step(1);
      sym_tick = 1'b0;
      step(1);
    end
  endtask

  // The line takes one word; valid must stand in the following cycle
  task automatic take(output logic [17:0] w);
    line_tx_ready = 1'b1;
    step(1);
    line_tx_ready = 1'b0;
    chk(line_tx_valid, 1'b1, "line valid");
    w = line_tx_data;
    step(2);
  endtask

  task automatic rx(input logic [17:0] w);
    line_rx_data = w;
    line_rx_valid = 1'b1;
    step(1);
    line_rx_valid = 1'b0;
    line_rx_data = ~w;
    chk(sys_rx_valid, 1'b1, "rx valid");
  endtask

  task automatic superframe(input logic up);
    link_up = up;
    sf_tick = 1'b1;
    step(1);
    sf_tick = 1'b0;
    step(1);
  endtask

  task automatic do_reset;
    rst = 1'b1;
    {train_done, sync_word_lock, zero_payload_detect} = 3'h0;
    superframe_lock = 1'b0;
    step(20);
    rst = 1'b0;
    step(1);
    chk(st, dss_pkg::ST_RESET, "reset state");
    chk(tc, 7'h00, "reset tx ctrl");
    chk(sys_tx_ready, 1'b1, "reset ready");
  endtask

  task automatic t_user;
    lt_mode = 1'b0;
    startup_request = 1'b1;
    step(1);
    startup_request = 1'b0;
    chk(st, dss_pkg::ST_TONE, "tone");
    chk({tc.tone, tc.sync_word, tc.quat}, {2'h2, dss_pkg::QUAT_POS3},
        "tone +3");
    syms(4);
    chk(tc.quat, dss_pkg::QUAT_NEG3, "tone -3");
    syms(4);
    chk(tc.quat, dss_pkg::QUAT_POS3, "tone repeat");
    frames(5);
    chk(st, dss_pkg::ST_TONE, "tone length");
    frames(1);
    chk(st, dss_pkg::ST_SYNC_ONLY, "sync only");
    chk({tc.sync_word, tc.inverted_sync_word, tc.overhead_ones}, 3'h5,
        "sync only ctrl");
    take(d);
    chk(d, dss_pkg::PAYLOAD_ONES, "forced ones");
    rx(18'h12345);
    chk(sys_rx_data, dss_pkg::PAYLOAD_ONES, "rx forced");
    train_done = 1'b1;
    step(2);
    chk({st, tc.enable}, {dss_pkg::ST_QUIET, 1'b0}, "quiet");
    sync_word_lock = 1'b1;
    step(3);
    chk(st, dss_pkg::ST_QUIET, "needs zeros");
    zero_payload_detect = 1'b1;
    step(2);
    chk(st, dss_pkg::ST_READY, "ready");
    chk({tc.inverted_sync_word, tc.overhead_ones}, 2'h1, "ready ctrl");
    superframe_lock = 1'b1;
    step(2);
    chk(st, dss_pkg::ST_NORMAL, "normal");
    chk({tc.inverted_sync_word, tc.overhead_ones}, 2'h2, "normal ctrl");
    take(d);
    chk(d, dss_pkg::PAYLOAD_ONES, "normal forced");
    rx(18'h2a5c3);
    chk(sys_rx_data, 18'h2a5c3, "rx passed");
    step(60);
    chk(st, dss_pkg::ST_NORMAL, "normal holds");
    $display("test user done");
  endtask

  // Broken link-up run must not clear; then fill the FIFO and drain it
  task automatic t_fifo;
    superframe(1'b1);
    superframe(1'b1);
    superframe(1'b0);
    superframe(1'b1);
    superframe(1'b1);
    take(d);
    chk(d, dss_pkg::PAYLOAD_ONES, "still blocked");
    superframe(1'b1);
    for (int i = 0; i < 16; i++)
    begin
      chk(sys_tx_ready, 1'b1, "room");
      sys_tx_data = 18'h100 + 18'(i);
      sys_tx_valid = 1'b1;
      step(1);
    end
    sys_tx_data = 18'h3fff0;
    step(1);
    sys_tx_valid = 1'b0;
    chk(sys_tx_ready, 1'b0, "full");
    for (int i = 0; i < 16; i++)
    begin
      take(d);
      chk(d, 18'h100 + 18'(i), "fifo order");
    end
    chk(sys_tx_ready, 1'b1, "drained");
    {loopback_request, startup_request} = 2'h3;
    step(2);
    chk(loopback_active, 1'b0, "loop yields");
    startup_request = 1'b0;
    step(2);
    chk(loopback_active, 1'b1, "loop on");
    rx(18'h0f0f0);
    take(d);
    chk(d, 18'h0f0f0, "loop data");
    loopback_request = 1'b0;
    deactivate_request = 1'b1;
    step(2);
    deactivate_request = 1'b0;
    chk(st, dss_pkg::ST_RESET, "deactivate");
    $display("test fifo done");
  endtask

  task automatic t_net;
    do_reset();
    lt_mode = 1'b1;
    line_signal_detect = 1'b1;
    tone_detect = 1'b1;
    step(1);
    tone_detect = 1'b0;
    chk({st, woke_by_tone}, {dss_pkg::ST_TONE, 1'b1}, "net tone");
    frames(1);
    chk(st, dss_pkg::ST_TONE, "net tone length");
    frames(1);
    step(4);
    chk(st, dss_pkg::ST_QUIET, "net waits");
    line_signal_detect = 1'b0;
    step(2);
    chk(st, dss_pkg::ST_SYNC_ONLY, "net sync");
    chk({tc.sync_word, tc.inverted_sync_word}, 2'h2, "net sync ctrl");
    train_done = 1'b1;
    step(2);
    chk({st, tc.inverted_sync_word}, {dss_pkg::ST_READY, 1'b1},
        "zero payload");
    take(d);
    chk(d, dss_pkg::PAYLOAD_ZEROS, "zeros");
    superframe_lock = 1'b1;
    step(2);
    chk(st, dss_pkg::ST_NORMAL, "net normal");
    take(d);
    chk(d, dss_pkg::PAYLOAD_ZEROS, "net forced");
    loop_msg = 1'b1;
    step(1);
    loop_msg = 1'b0;
    sys_tx_data = 18'h15a5a;
    sys_tx_valid = 1'b1;
    step(1);
    sys_tx_valid = 1'b0;
    take(d);
    chk(d, 18'h15a5a, "echo clears");
    $display("test net done");
  endtask

  task automatic t_prio;
    do_reset();
    lt_mode = 1'b0;
    {startup_request, tone_detect, insertion_loss_test} = 3'h7;
    step(2);
    chk({st, insertion_loss_test_active}, {dss_pkg::ST_INSERTION_LOSS_TEST, 1'b1}, "test wins");
    filter_reset_request = 1'b1;
    step(2);
    chk(st, dss_pkg::ST_RESET, "filter reset wins");
    filter_reset_request = 1'b0;
    {startup_request, tone_detect} = 2'h0;
    step(2);
    chk(st, dss_pkg::ST_INSERTION_LOSS_TEST, "test again");
    insertion_loss_test = 1'b0;
    step(2);
    chk(st, dss_pkg::ST_RESET, "test ends");
    {startup_request, tone_detect} = 2'h3;
    step(1);
    chk({st, woke_by_tone}, {dss_pkg::ST_TONE, 1'b1}, "tone wins");
    $display("test prio done");
  endtask

  task automatic conclude;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    #200000;
    n_mismatch++;
    conclude();
  end

  initial
  begin
    #2;
    do_reset();
    t_user();
    t_fifo();
    t_net();
    t_prio();
    conclude();
  end
endmodule
